/* hw/trca_pkg.sv */
package trca_pkg;
  localparam int          TRCA_TRACKS        = 9;
  localparam int          TRCA_CLK_HZ        = 10_000_000;
  // tape speed in inches per second, a plain default
  localparam int          TRCA_TAPE_IPS      = 45;
  localparam int          TRCA_BPI_HI        = 800;
  localparam int          TRCA_BPI_LO        = 556;
  localparam int          TRCA_PEAK_DELAY_NS = 400;
  localparam int          TRCA_STROBE_US     = 1;
  localparam int          TRCA_STROBE_CYC    =
    (TRCA_STROBE_US * TRCA_CLK_HZ + 999_999) / 1_000_000;
  localparam int          TRCA_PEAK_DLY_CYC  =
    (TRCA_PEAK_DELAY_NS * (TRCA_CLK_HZ / 1_000_000) + 999) / 1000;
  // half a character period in cycles: clk / (2 * ips * bpi), rounded down
  localparam int          TRCA_WIN_HI_CYC    = TRCA_CLK_HZ / (2 * TRCA_TAPE_IPS * TRCA_BPI_HI);
  localparam int          TRCA_WIN_LO_CYC    = TRCA_CLK_HZ / (2 * TRCA_TAPE_IPS * TRCA_BPI_LO);
  localparam int          TRCA_CNT_W         = 12;
  localparam int          TRCA_FIFO_DEPTH    = 4;
  // threshold codes in tenths of a volt, for the dac
  localparam logic [4:0]  TRCA_THR_NORMAL    = 5'h0c;
  localparam logic [4:0]  TRCA_THR_LOWCLIP   = 5'h07;
  localparam logic [4:0]  TRCA_THR_WRITE     = 5'h14;
  localparam logic [1:0]  TRCA_SEL_NORMAL    = 2'h0;
  localparam logic [1:0]  TRCA_SEL_LOWCLIP   = 2'h1;
  localparam logic [1:0]  TRCA_SEL_WRITE     = 2'h2;
  typedef enum logic [1:0] {
    TRCA_IDLE   = 2'b00,
    TRCA_WINDOW = 2'b01,
    TRCA_STROBE = 2'b10
  } trca_state_e;
endpackage

/* hw/trca_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module trca_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,      // clock
  input  wire logic             srst,     // sync reset
  input  wire logic             in_valid, // write request
  output logic                  in_ready, // room left
  input  wire logic [WIDTH-1:0] in_data,  // write word
  output logic                  out_valid,// word waiting
  input  wire logic             out_ready,// reader takes
  output logic      [WIDTH-1:0] out_data  // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              do_wr = in_valid && in_ready;
  wire              do_rd = out_valid && out_ready;
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule
`default_nettype wire

/* hw/trca_top.sv */
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - writing always selects the high verify threshold for peak detection
// - reading uses normal or low-clip threshold chosen by operator switch
// - a track detects a 1 only with delayed peak and amplitude over threshold
// - peak indication stays true until the track's next data pulse
// - detected 1 sets its track cell; cell stays set until register clear
// - all nine register cells drive the read data lines continuously
// - first 1 of a character starts half-character window; not restarted
// - window expiry gives one strobe pulse of one microsecond
// - strobe trailing edge clears every register cell
// - erase head energized during every write and erase operation while no write lock is set
// - write lock disables erase head regardless of requests
// - missing write ring asserts write lock and unpowers write drivers
module trca_top
  import trca_pkg::*;
#(
  parameter int TRACKS    = TRCA_TRACKS,
  parameter int FIFO_DEPTH = TRCA_FIFO_DEPTH
) (
  input  wire logic              clk,          // 10 mhz logic clock
  input  wire logic              srst,         // sync reset, active high
  input  wire logic [TRACKS-1:0] pulse_in,     // per-track data pulse start
  input  wire logic [TRACKS-1:0] peak_in,      // per-track undelayed peak
  input  wire logic [TRACKS-1:0] above_thr,    // per-track amplitude over threshold
  input  wire logic              writing,      // write operation active
  input  wire logic              erasing,      // erase operation active
  input  wire logic              reading,      // read or space active
  input  wire logic              low_clip_sw,  // operator low-clip switch
  input  wire logic              density_lo,   // 1 selects low density
  input  wire logic              ring_absent,  // no write-enable ring sensed
  output logic      [4:0]        thr_code,     // threshold dac code
  output logic      [1:0]        thr_sel,      // selected threshold
  output logic      [TRACKS-1:0] rd_data,      // read data lines, parity at msb
  output logic                   rd_strobe,    // one microsecond data strobe
  output logic                   erase_on,     // erase head drive
  output logic                   write_locked, // write lock to controller
  output logic                   write_pwr,    // write driver power enable
  output logic                   char_valid,   // assembled character waiting
  input  wire logic              char_ready,   // consumer takes character
  output logic      [TRACKS-1:0] char_data     // assembled character
);
  // pin synchronisers
  logic [TRACKS-1:0] pulse_s1, pulse_s2, pulse_s3;
  logic [TRACKS-1:0] peak_s1, peak_s2;
  logic [TRACKS-1:0] thr_s1, thr_s2;
  logic [5:0]        ctl_s1, ctl_s2;
  always_ff @(posedge clk) begin
    pulse_s1 <= pulse_in;
    pulse_s2 <= pulse_s1;
    pulse_s3 <= pulse_s2;
    peak_s1  <= peak_in;
    peak_s2  <= peak_s1;
    thr_s1   <= above_thr;
    thr_s2   <= thr_s1;
    ctl_s1   <= {writing, erasing, reading, low_clip_sw, density_lo, ring_absent};
    ctl_s2   <= ctl_s1;
  end
  wire w_wr   = ctl_s2[5];
  wire w_er   = ctl_s2[4];
  wire w_rd   = ctl_s2[3];
  wire w_low  = ctl_s2[2];
  wire w_dlo  = ctl_s2[1];
  wire w_lock = ctl_s2[0];
  wire [TRACKS-1:0] pulse_rise = pulse_s2 & ~pulse_s3;

  // threshold selection
  wire [1:0] next_thr_sel = w_wr ? TRCA_SEL_WRITE
                          : (w_low ? TRCA_SEL_LOWCLIP : TRCA_SEL_NORMAL);
  wire [4:0] next_thr_code = (next_thr_sel == TRCA_SEL_WRITE)   ? TRCA_THR_WRITE
                           : (next_thr_sel == TRCA_SEL_LOWCLIP) ? TRCA_THR_LOWCLIP
                           : TRCA_THR_NORMAL;
  always_ff @(posedge clk) begin
    if (srst) begin
      thr_sel  <= TRCA_SEL_NORMAL;
      thr_code <= TRCA_THR_NORMAL;
    end else begin
      thr_sel  <= next_thr_sel;
      thr_code <= next_thr_code;
    end
  end

  // delayed peak per track: delay line then hold until next pulse
  localparam int PD = TRCA_PEAK_DLY_CYC;
  logic [TRACKS-1:0] peak_dly [PD];
  logic [TRACKS-1:0] peak_hold;
  logic [TRACKS-1:0] cell_done;
  always_ff @(posedge clk) begin
    peak_dly[0] <= peak_s2;
    for (int i = 1; i < PD; i++) begin
      peak_dly[i] <= peak_dly[i-1];
    end
  end
  wire [TRACKS-1:0] peak_late = peak_dly[PD-1];
  always_ff @(posedge clk) begin
    if (srst) begin
      peak_hold <= '0;
    end else begin
      peak_hold <= (peak_hold | peak_late) & ~pulse_rise;
    end
  end
  wire [TRACKS-1:0] peak_ind = peak_hold | peak_late;
  // one detection per held peak
  wire [TRACKS-1:0] one_det  = peak_ind & thr_s2 & ~cell_done;
  wire              active   = w_rd | w_wr;

  // character assembly
  trca_state_e       state, next_state;
  logic [TRACKS-1:0] cells;
  logic [TRACKS-1:0] next_cells;
  logic [TRACKS-1:0] next_done;
  logic [TRCA_CNT_W-1:0] cnt, next_cnt;
  wire [TRCA_CNT_W-1:0] win_len = w_dlo ? TRCA_CNT_W'(TRCA_WIN_LO_CYC)
                                        : TRCA_CNT_W'(TRCA_WIN_HI_CYC);
  wire any_det   = active && (one_det != '0);
  wire strobe_end = (state == TRCA_STROBE) && (cnt == '0);
  wire fifo_in_ready;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_cells = cells;
    next_done  = (cell_done | (active ? one_det : '0)) & ~pulse_rise;
    if (active) begin
      next_cells = cells | one_det;
    end
    unique case (state)
      TRCA_IDLE: begin
        if (any_det) begin
          next_state = TRCA_WINDOW;
          next_cnt   = win_len - 1'b1;
        end
      end
      TRCA_WINDOW: begin
        if (cnt == '0) begin
          next_state = TRCA_STROBE;
          next_cnt   = TRCA_CNT_W'(TRCA_STROBE_CYC - 1);
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      TRCA_STROBE: begin
        if (cnt == '0) begin
          next_state = TRCA_IDLE;
          next_cells = '0;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: begin
        next_state = TRCA_IDLE;
        next_cnt   = '0;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      state     <= TRCA_IDLE;
      cnt       <= '0;
      cells     <= '0;
      cell_done <= '0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      cells     <= next_cells;
      cell_done <= next_done;
    end
  end
  assign rd_data   = cells;
  assign rd_strobe = (state == TRCA_STROBE);

  // characters queued at strobe end; full fifo drops the character
  trca_fifo #(
    .WIDTH (TRACKS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (strobe_end),
    .in_ready  (fifo_in_ready),
    .in_data   (cells),
    .out_valid (char_valid),
    .out_ready (char_ready),
    .out_data  (char_data)
  );
  logic overrun;
  always_ff @(posedge clk) begin
    if (srst) begin
      overrun <= 1'b0;
    end else if (strobe_end && !fifo_in_ready) begin
      overrun <= 1'b1;
    end
  end

  // write protection and erase
  always_ff @(posedge clk) begin
    if (srst) begin
      erase_on     <= 1'b0;
      write_locked <= 1'b0;
      write_pwr    <= 1'b0;
    end else begin
      erase_on     <= (w_wr | w_er) & ~w_lock;
      write_locked <= w_lock;
      write_pwr    <= ~w_lock;
    end
  end
endmodule
`default_nettype wire

/* test/trca_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module trca_chk
  import trca_pkg::*;
#(
  parameter int TRACKS = TRCA_TRACKS
) (
  input wire logic              clk,          // clock
  input wire logic              srst,         // reset
  input wire logic              writing,      // write op
  input wire logic              erasing,      // erase op
  input wire logic              reading,      // read op
  input wire logic              low_clip_sw,  // switch
  input wire logic              density_lo,   // density
  input wire logic              ring_absent,  // no ring
  input wire logic [4:0]        thr_code,     // dac code
  input wire logic [1:0]        thr_sel,      // threshold
  input wire logic [TRACKS-1:0] rd_data,      // cells
  input wire logic              rd_strobe,    // strobe
  input wire logic              erase_on,     // erase head
  input wire logic              write_locked, // lock
  input wire logic              write_pwr     // drivers
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  int s_cnt;
  int w_cnt;
  always_ff @(posedge clk) begin
    s_cnt <= (srst || !rd_strobe) ? 0 : s_cnt + 1;
    w_cnt <= (srst || rd_strobe || rd_data == '0) ? 0 : w_cnt + 1;
  end
  a_thr_write: assert property (writing [*6] |->
    thr_sel == TRCA_SEL_WRITE && thr_code == TRCA_THR_WRITE) else $error("write level missing");
  a_thr_low: assert property ((reading && !writing && low_clip_sw) [*6] |->
    thr_sel == TRCA_SEL_LOWCLIP && thr_code == TRCA_THR_LOWCLIP) else $error("low clip missing");
  a_thr_norm: assert property ((reading && !writing && !low_clip_sw) [*6] |->
    thr_sel == TRCA_SEL_NORMAL && thr_code == TRCA_THR_NORMAL) else $error("normal missing");
  // w_cnt holds the window cycles seen with cells set, so it equals the window length
  a_win_len: assert property ($rose(rd_strobe) |-> w_cnt ==
    (density_lo ? TRCA_WIN_LO_CYC : TRCA_WIN_HI_CYC)) else $error("window length wrong");
  a_strobe_max: assert property (rd_strobe |-> s_cnt < TRCA_STROBE_CYC)
    else $error("strobe too long");
  a_strobe_len: assert property ($fell(rd_strobe) |-> s_cnt == TRCA_STROBE_CYC)
    else $error("strobe too short");
  a_clear_end: assert property ($fell(rd_strobe) |-> rd_data == '0)
    else $error("cells not cleared");
  a_cells_keep: assert property (!$fell(rd_strobe) |-> ($past(rd_data) & ~rd_data) == '0)
    else $error("cell lost early");
  a_erase_on: assert property (((writing || erasing) && !ring_absent) [*6] |-> erase_on)
    else $error("erase head off");
  a_lock_gate: assert property (ring_absent [*6] |->
    !erase_on && write_locked && !write_pwr) else $error("lock not honoured");
endmodule
bind trca_top trca_chk #(.TRACKS(TRACKS)) u_chk (.clk, .srst, .writing, .erasing, .reading,
  .low_clip_sw, .density_lo, .ring_absent, .thr_code, .thr_sel, .rd_data, .rd_strobe,
  .erase_on, .write_locked, .write_pwr);
`default_nettype wire

/* test/trca_ctrl_model.sv */
`timescale 1ns/100ps
`default_nettype none
module trca_ctrl_model (
  input wire logic clk,        // clock
  input wire logic srst,       // reset
  input wire logic stall,      // hold off
  input wire logic slow,       // take every other cycle
  input wire logic char_valid, // word waiting
  output logic     char_ready, // take word
  output logic     rec_ok      // record long enough
);
  logic phase;
  int   count;
  always_ff @(posedge clk) begin
    phase <= srst ? 1'b0 : ~phase;
    count <= srst ? 0 : count + int'(char_valid && char_ready);
  end
  assign char_ready = !stall && (!slow || phase);
  assign rec_ok = count >= 3;
endmodule
`default_nettype wire

/* test/trca_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module trca_top_tb;
  import trca_pkg::*;
  logic        clk, srst, writing, erasing, reading, low_clip_sw, density_lo, ring_absent;
  logic        stall, slow, char_valid, char_ready, rd_strobe, erase_on, write_locked;
  logic        write_pwr, rec_ok;
  logic [8:0]  pulse_in, peak_in, above_thr, rd_data, char_data, e, r;
  logic [4:0]  thr_code;
  logic [1:0]  thr_sel;
  logic [31:0] seed;
  logic [8:0]  exp_q[$];
  int          fail_count, checks_done, n;
  trca_top uut (.clk, .srst, .pulse_in, .peak_in, .above_thr, .writing, .erasing, .reading,
    .low_clip_sw, .density_lo, .ring_absent, .thr_code, .thr_sel, .rd_data, .rd_strobe,
    .erase_on, .write_locked, .write_pwr, .char_valid, .char_ready, .char_data);
  trca_ctrl_model ctrl (.clk, .srst, .stall, .slow, .char_valid, .char_ready, .rec_ok);
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int win_cyc(logic lo);
    return lo ? TRCA_WIN_LO_CYC : TRCA_WIN_HI_CYC;
  endfunction
  function automatic logic [8:0] thr_exp(int i);
    return 9'(i == 2 ? TRCA_THR_WRITE : i == 1 ? TRCA_THR_LOWCLIP : TRCA_THR_NORMAL);
  endfunction
  task automatic tick(int k = 1);
    repeat (k) @(posedge clk);
    #10;
  endtask
  task automatic cmp(string what, logic [8:0] exp, logic [8:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic guard(int lim);
    if (n >= lim) begin
      $display("mismatch wait expected below %0d seen %0d", lim, n);
      fail_count++;
      end_of_test();
    end
  endtask
  // frame a opens the window; b arrives late and must not restart it
  task automatic send_char(logic [8:0] a, logic [8:0] b, logic [8:0] amp);
    e = (a | b) & amp;
    pulse_in = a;
    tick(2);
    pulse_in = '0;
    peak_in = a;
    // only tracks that carry a pulse may be over threshold, else a held peak fires early
    above_thr = amp & (a | b);
    tick(2);
    peak_in = '0;
    n = 0;
    while (rd_data === '0 && n < 40) begin
      tick();
      n++;
    end
    guard(40);
    n = 0;
    while (rd_strobe !== 1'b1 && n < 400) begin
      tick();
      n++;
      pulse_in = (n == 20) ? b : '0;
      peak_in = (n == 22) ? b : '0;
    end
    guard(400);
    cmp("window", 9'(win_cyc(density_lo)), 9'(n));
    cmp("cells", e, rd_data);
    // queued before the strobe ends, as the fifo pops it one cycle after it enters
    if (exp_q.size() < TRCA_FIFO_DEPTH)
      exp_q.push_back(e);
    n = 0;
    while (rd_strobe === 1'b1 && n < 40) begin
      tick();
      n++;
    end
    guard(40);
    cmp("strobe width", 9'(TRCA_STROBE_CYC), 9'(n));
    cmp("cleared", '0, rd_data);
    above_thr = '0;
    tick(8);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (srst === 1'b0 && char_valid === 1'b1 && char_ready === 1'b1) begin
      cmp("fifo char", exp_q[0], char_data);
      void'(exp_q.pop_front());
    end
  end
  initial begin
    {pulse_in, peak_in, above_thr} = '0;
    {writing, erasing, reading, low_clip_sw, density_lo, ring_absent, stall, slow} = '0;
    seed = 32'h0000fd14;
    fail_count = 0;
    checks_done = 0;
    srst = 1'b1;
    tick(6);
    srst = 1'b0;
    reading = 1'b1;
    for (int i = 0; i < 3; i++) begin
      writing = (i == 2);
      low_clip_sw = (i != 0);
      tick(6);
      cmp("thr sel", 9'(i), 9'(thr_sel));
      cmp("thr code", thr_exp(i), 9'(thr_code));
    end
    $display("test thresholds done");
    for (int i = 0; i < 8; i++) begin
      {ring_absent, erasing, writing} = i[2:0];
      tick(6);
      cmp("erase", 9'((i[0] | i[1]) && !i[2]), 9'(erase_on));
      cmp("lock", 9'(i[2]), 9'(write_locked));
      cmp("write power", 9'(!i[2]), 9'(write_pwr));
    end
    {ring_absent, erasing, writing, low_clip_sw} = '0;
    $display("test erase done");
    for (int d = 0; d < 2; d++) begin
      density_lo = d[0];
      tick(4);
      send_char(9'h001, 9'h100, 9'h1ff);
    end
    $display("test window done");
    for (int k = 0; k < 6; k++) begin
      void'(xs());
      {writing, reading} = {seed[20], ~seed[20]};
      r = {~^seed[7:0], seed[7:0]};
      void'(xs());
      tick(4);
      send_char(r, '0, seed[8:0] | (r & (~r + 9'h001)));
    end
    $display("test random done");
    {writing, reading, stall} = 3'h3;
    for (int k = 0; k < 5; k++) begin
      void'(xs());
      send_char({1'b1, seed[7:0]}, '0, 9'h1ff);
    end
    cmp("full valid", 9'h001, 9'(char_valid));
    {slow, stall} = 2'h2;
    n = 0;
    while (exp_q.size() != 0 && n < 100) begin
      tick();
      n++;
    end
    guard(100);
    tick(4);
    cmp("drained", '0, 9'(char_valid));
    cmp("record ok", 9'h001, 9'(rec_ok));
    $display("test fifo done");
    end_of_test();
  end
endmodule
`default_nettype wire
